// ==== rtl/lmio_pkg.sv ====
// package: constants, register map and state types of the io supervisor
// assumes a 200 MHz system clock
package lmio_pkg;
  localparam int unsigned CLK_HZ       = 200_000_000;
  localparam int unsigned PEDAL_MS     = 100;
  localparam int unsigned PEDAL_CYC    = PEDAL_MS * (CLK_HZ / 1000);
  localparam int unsigned HOME_PER_US  = 50;
  localparam int unsigned HOME_PER_CYC = HOME_PER_US * (CLK_HZ / 1000000);
  localparam int unsigned HOME_PUL_US  = 5;
  localparam int unsigned HOME_PUL_CYC = HOME_PUL_US * (CLK_HZ / 1000000);
  localparam int CNT_W      = 25;
  localparam int HOME_W     = 16;
  localparam int NUM_AXES   = 4;
  localparam int NUM_LASERS = 2;
  localparam int NUM_LIMITS = 8;
  localparam int NUM_IN     = 13;
  // bit positions in the synchronised input vector
  localparam int IN_PEDAL = 0;
  localparam int IN_GUARD = 1;
  localparam int IN_FIRE  = 2;
  localparam int IN_LIMIT = 3;
  localparam int IN_COOL  = 11;
  localparam logic [NUM_IN-1:0] SYNC_RST = 13'h1FFF;
  // register byte offsets
  localparam logic [3:0] CFG_OFS  = 4'h0;
  localparam logic [3:0] CMD_OFS  = 4'h4;
  localparam logic [3:0] STAT_OFS = 4'h8;
  // configuration fields
  localparam int CFG_GUARD_EN = 0;
  localparam int CFG_COOL_EN  = 1;
  localparam int CFG_LIMIT_HI = 3;
  localparam int CFG_GLASS    = 4;
  localparam int CFG_DIR_INV  = 8;
  localparam int CFG_STEP_RISE = 12;
  localparam logic [15:0] CFG_RST = 16'h0000;
  // command fields, write-only pulses
  localparam int CMD_KEY  = 0;
  localparam int CMD_STOP = 1;
  localparam int CMD_HOME = 4;
  // status fields
  localparam int ST_JOB   = 0;
  localparam int ST_PROT  = 2;
  localparam int ST_WARN  = 3;
  localparam int ST_GUARD = 5;
  localparam int ST_LIMIT = 6;
  localparam int ST_HOME  = 14;
  localparam int ST_LASER = 18;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {JOB_IDLE, JOB_RUN, JOB_PAUSE} lmio_job_t;

  typedef struct packed {
    logic [NUM_IN-1:0] s1;
    logic [NUM_IN-1:0] s2;
    logic [NUM_IN-1:0] s3;
    logic [NUM_IN-1:0] q;
  } lmio_sync_t;

  typedef struct packed {
    logic                  aw_got;
    logic                  w_got;
    logic [3:0]            awaddr;
    logic [31:0]           wdata;
    logic [3:0]            wstrb;
    logic                  bvalid;
    logic [1:0]            bresp;
    logic                  rvalid;
    logic [31:0]           rdata;
    logic [1:0]            rresp;
    logic [15:0]           cfg;
    lmio_job_t             job;
    logic [CNT_W-1:0]      hold_cnt;
    logic [CNT_W-1:0]      gap_cnt;
    logic                  press_used;
    logic [NUM_AXES-1:0]   homing;
    logic [HOME_W-1:0]     home_cnt;
    logic [NUM_AXES-1:0]   step_pin;
    logic [NUM_AXES-1:0]   dir_pin;
    logic [NUM_LASERS-1:0] laser_on;
    logic [NUM_LASERS-1:0] en_pin;
    logic [NUM_LASERS-1:0] pwm_pin;
    logic [NUM_LASERS-1:0] warn;
    logic [NUM_LIMITS-1:0] lamp;
  } lmio_state_t;
endpackage

// ==== rtl/lmio_sync3.sv ====
// three-stage input synchroniser with agreement qualify
// assumes asynchronous pins; every stage and the qualified output reset high
`timescale 1ns/1ps
module lmio_sync3 (
  input  wire logic                      clock,
  input  wire logic                      rst_n,
  input  wire logic                      clock_en,
  input  wire logic [lmio_pkg::NUM_IN-1:0] async_in,
  output logic      [lmio_pkg::NUM_IN-1:0] sync_out
);
  lmio_pkg::lmio_sync_t st;
  lmio_pkg::lmio_sync_t next_st;

  // s1 feeds only s2; a change counts once s2 and s3 agree
  always_comb begin
    next_st    = st;
    next_st.s1 = async_in;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    next_st.q  = (st.s2 & st.s3) | (st.q & (st.s2 ^ st.s3));
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st <= {4{lmio_pkg::SYNC_RST}};
    end else if (clock_en) begin
      st <= next_st;
    end
  end

  assign sync_out = st.q;

  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);

  property p_sync_agree;
    clock_en && (st.s2 == st.s3) |=> (st.q == $past(st.s3));
  endproperty
  a_sync_agree: assert property (p_sync_agree)
    else $error("qualified input missed an agreed level");

  property p_sync_hold;
    clock_en && (st.s2 != st.s3) |=> (st.q == $past(st.q));
  endproperty
  a_sync_hold: assert property (p_sync_hold)
    else $error("qualified input moved while stages disagree");
endmodule

// ==== rtl/lmio_top.sv ====
// machine io supervisor: pedal, guard, manual fire, limits,
// four step/dir axes, two laser channels; axi4-lite registers
// assumes one 200 MHz clock; motion and pwm generators are upstream
//
// Functional notes
// - press held low 100 ms toggles start, pause and resume like the key.
// - press starting under 100 ms after an accepted press is ignored.
// - guard disabled means its input is not sampled and has no effect.
// - enabled guard high or open pauses work and switches laser off.
// - manual fire low turns laser on, high or open turns it off.
// - each axis has a minus limit toward zero and plus toward max.
// - limit active level is configurable; low-active means low at limit.
// - each limit lamp lights while its input is low.
// - four identical axes, each with direction and step pulse outputs.
// - direction polarity per axis is configurable.
// - step active edge selectable, falling after reset.
// - homing drives the axis toward origin until its minus limit.
// - two independent laser channels with enable, pwm and coolant guard.
// - laser type per channel selects rf or glass tube driving.
// - enable unused for rf; glass tube low means supply on.
// - power pwm carries rf modulation or glass tube power pwm.
// - enabled coolant high forces laser off, pauses work, warns.
// - disabled coolant guard input is not sampled.
//
// Local design decisions: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module lmio_top #(
  parameter int unsigned PEDAL_CYC    = lmio_pkg::PEDAL_CYC,
  parameter int unsigned HOME_PER_CYC = lmio_pkg::HOME_PER_CYC,
  parameter int unsigned HOME_PUL_CYC = lmio_pkg::HOME_PUL_CYC
) (
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        clock_en,
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        pedal_switch_in,
  input  wire logic        guard_interlock_in,
  input  wire logic        manual_fire_in,
  input  wire logic [7:0]  axis_limit_in,
  input  wire logic [1:0]  coolant_guard_in,
  input  wire logic [3:0]  axis_step_req,
  input  wire logic [3:0]  axis_dir_req,
  input  wire logic [1:0]  laser_fire_req,
  input  wire logic [1:0]  laser_pwm_req,
  output logic [3:0]       axis_step_pulse_out,
  output logic [3:0]       axis_dir_out,
  output logic [1:0]       laser_enable_out,
  output logic [1:0]       laser_power_pwm_out,
  output logic [1:0]       coolant_warn_out,
  output logic [7:0]       limit_lamp_out,
  output logic             job_running_out
);
  localparam int NA = lmio_pkg::NUM_AXES;
  localparam int NL = lmio_pkg::NUM_LASERS;
  localparam logic [lmio_pkg::CNT_W-1:0] CNT_W_MAX =
    lmio_pkg::CNT_W'(PEDAL_CYC - 1);
  lmio_pkg::lmio_state_t st;
  lmio_pkg::lmio_state_t next_st;
  logic [lmio_pkg::NUM_IN-1:0] q;
  logic [7:0]        raw_lim, at_lim;
  logic              pressed, acc, guard_trip, prot_any, home_pulse;
  logic [NL-1:0]     cool_trip, trip;
  logic [NA-1:0]     step_nx, dir_nx;
  logic [NL-1:0]     on_nx, en_nx, pwm_nx;
  logic [31:0]       stat_word;
  logic              do_write, cmd_key, cmd_stop;
  logic [1:0]        w_idx;
  logic [NA-1:0]     cmd_home;
  // all pins pass the synchroniser; each qualified bit resets high
  lmio_sync3 u_sync (
    .clock    (clock),
    .rst_n    (rst_n),
    .clock_en (clock_en),
    .async_in ({coolant_guard_in, axis_limit_in, manual_fire_in,
                guard_interlock_in, pedal_switch_in}),
    .sync_out (q)
  );
  // open pins read high, so an unwired guard trips as protection
  assign guard_trip = st.cfg[lmio_pkg::CFG_GUARD_EN]
                    & q[lmio_pkg::IN_GUARD];
  assign cool_trip  = st.cfg[lmio_pkg::CFG_COOL_EN +: NL]
                    & q[lmio_pkg::IN_COOL +: NL];
  assign trip       = {NL{guard_trip}} | cool_trip;
  assign prot_any   = guard_trip | (|cool_trip);
  assign raw_lim    = q[lmio_pkg::IN_LIMIT +: 8];
  // even bit = minus limit toward zero, odd bit = plus limit
  assign at_lim     = st.cfg[lmio_pkg::CFG_LIMIT_HI] ?
                      raw_lim : ~raw_lim;
  assign pressed    = ~q[lmio_pkg::IN_PEDAL];
  assign acc        = pressed && !st.press_used
                      && (st.hold_cnt == CNT_W_MAX);
  assign home_pulse = st.home_cnt < lmio_pkg::HOME_W'(HOME_PUL_CYC);
  generate
    for (genvar a = 0; a < NA; a++) begin : g_axis
      logic act;
      logic dir_l;
      // homing steps toward the minus limit, direction 0 is minus
      assign act   = axis_step_req[a] | (st.homing[a] & home_pulse);
      assign dir_l = st.homing[a] ? 1'b0 : axis_dir_req[a];
      assign dir_nx[a]  = dir_l
        ^ st.cfg[lmio_pkg::CFG_DIR_INV + a];
      assign step_nx[a] = st.cfg[lmio_pkg::CFG_STEP_RISE + a] ?
                          act : ~act;
    end
    for (genvar c = 0; c < NL; c++) begin : g_laser
      logic want;
      logic glass;
      assign glass = st.cfg[lmio_pkg::CFG_GLASS + c];
      assign want  = ~q[lmio_pkg::IN_FIRE]
        | (laser_fire_req[c] & (st.job == lmio_pkg::JOB_RUN));
      assign on_nx[c]  = want & ~trip[c];
      assign en_nx[c]  = ~(glass & on_nx[c]);
      assign pwm_nx[c] = laser_pwm_req[c] & on_nx[c];
    end
  endgenerate
  always_comb begin
    stat_word = 32'h0000_0000;
    stat_word[lmio_pkg::ST_JOB +: 2]   = st.job;
    stat_word[lmio_pkg::ST_PROT]       = prot_any;
    stat_word[lmio_pkg::ST_WARN +: NL] = st.warn;
    stat_word[lmio_pkg::ST_GUARD]      = guard_trip;
    stat_word[lmio_pkg::ST_LIMIT +: 8] = at_lim;
    stat_word[lmio_pkg::ST_HOME +: NA] = st.homing;
    stat_word[lmio_pkg::ST_LASER +: NL] = st.laser_on;
  end
  assign s_axi_awready = !st.aw_got && !st.bvalid;
  assign s_axi_wready  = !st.w_got && !st.bvalid;
  assign s_axi_arready = !st.rvalid;
  assign do_write      = st.aw_got && st.w_got && !st.bvalid;
  assign w_idx         = st.awaddr[3:2];
  assign cmd_key  = do_write && (w_idx == lmio_pkg::CMD_OFS[3:2])
                    && st.wstrb[0] && st.wdata[lmio_pkg::CMD_KEY];
  assign cmd_stop = do_write && (w_idx == lmio_pkg::CMD_OFS[3:2])
                    && st.wstrb[0] && st.wdata[lmio_pkg::CMD_STOP];
  assign cmd_home = (do_write && (w_idx == lmio_pkg::CMD_OFS[3:2])
                    && st.wstrb[0]) ?
                    st.wdata[lmio_pkg::CMD_HOME +: NA] : '0;
  always_comb begin
    next_st = st;
    // write channel: address and data taken in either order
    if (s_axi_awvalid && s_axi_awready) begin
      next_st.aw_got = 1'b1;
      next_st.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_st.w_got = 1'b1;
      next_st.wdata = s_axi_wdata;
      next_st.wstrb = s_axi_wstrb;
    end
    if (st.bvalid && s_axi_bready) begin
      next_st.bvalid = 1'b0;
    end
    if (do_write) begin
      next_st.aw_got = 1'b0;
      next_st.w_got  = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp  = lmio_pkg::RESP_OKAY;
      case (w_idx)
        lmio_pkg::CFG_OFS[3:2]: begin
          if (st.wstrb[0]) begin
            next_st.cfg[7:0] = st.wdata[7:0];
          end
          if (st.wstrb[1]) begin
            next_st.cfg[15:8] = st.wdata[15:8];
          end
        end
        lmio_pkg::CMD_OFS[3:2]: begin
        end
        default: begin
          // status is read-only; unmapped gets slverr too
          next_st.bresp = lmio_pkg::RESP_SLVERR;
        end
      endcase
    end
    // read channel: answer the cycle after the address is taken
    if (st.rvalid && s_axi_rready) begin
      next_st.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      next_st.rvalid = 1'b1;
      next_st.rresp  = lmio_pkg::RESP_OKAY;
      case (s_axi_araddr[3:2])
        lmio_pkg::CFG_OFS[3:2]:  next_st.rdata = {16'h0000, st.cfg};
        lmio_pkg::CMD_OFS[3:2]:  next_st.rdata = 32'h0000_0000;
        lmio_pkg::STAT_OFS[3:2]: next_st.rdata = stat_word;
        default: begin
          next_st.rdata = 32'h0000_0000;
          next_st.rresp = lmio_pkg::RESP_SLVERR;
        end
      endcase
    end
    // pedal: qualify hold time, then lock out early repeats
    if (st.gap_cnt != '0) begin
      next_st.gap_cnt = st.gap_cnt - 1'b1;
    end
    if (!pressed) begin
      next_st.hold_cnt   = '0;
      next_st.press_used = 1'b0;
    end else if (!st.press_used) begin
      if (st.hold_cnt == '0 && st.gap_cnt != '0) begin
        next_st.press_used = 1'b1;
      end else if (acc) begin
        next_st.press_used = 1'b1;
        next_st.gap_cnt    = CNT_W_MAX;
      end else begin
        next_st.hold_cnt = st.hold_cnt + 1'b1;
      end
    end
    // job state; protection pauses and blocks resume
    case (st.job)
      lmio_pkg::JOB_IDLE: begin
        if ((acc || cmd_key) && !prot_any) begin
          next_st.job = lmio_pkg::JOB_RUN;
        end
      end
      lmio_pkg::JOB_RUN: begin
        if (prot_any || acc || cmd_key) begin
          next_st.job = lmio_pkg::JOB_PAUSE;
        end
      end
      lmio_pkg::JOB_PAUSE: begin
        if ((acc || cmd_key) && !prot_any) begin
          next_st.job = lmio_pkg::JOB_RUN;
        end
      end
      default: next_st.job = lmio_pkg::JOB_IDLE;
    endcase
    if (cmd_stop) begin
      next_st.job = lmio_pkg::JOB_IDLE;
    end
    // homing ends when the minus limit is seen
    next_st.homing = (st.homing | cmd_home)
                   & ~{at_lim[6], at_lim[4],
                       at_lim[2], at_lim[0]};
    if (st.homing == '0 ||
        st.home_cnt == lmio_pkg::HOME_W'(HOME_PER_CYC - 1)) begin
      next_st.home_cnt = '0;
    end else begin
      next_st.home_cnt = st.home_cnt + 1'b1;
    end
    next_st.step_pin = step_nx;
    next_st.dir_pin  = dir_nx;
    next_st.laser_on = on_nx;
    next_st.en_pin   = en_nx;
    next_st.pwm_pin  = pwm_nx;
    next_st.warn     = cool_trip;
    next_st.lamp     = ~raw_lim;
  end
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st          <= '0;
      st.cfg      <= lmio_pkg::CFG_RST;
      st.job      <= lmio_pkg::JOB_IDLE;
      st.step_pin <= '1;
      st.en_pin   <= '1;
    end else if (clock_en) begin
      st <= next_st;
    end
  end
  assign s_axi_bvalid        = st.bvalid;
  assign s_axi_bresp         = st.bresp;
  assign s_axi_rvalid        = st.rvalid;
  assign s_axi_rdata         = st.rdata;
  assign s_axi_rresp         = st.rresp;
  assign axis_step_pulse_out = st.step_pin;
  assign axis_dir_out        = st.dir_pin;
  assign laser_enable_out    = st.en_pin;
  assign laser_power_pwm_out = st.pwm_pin;
  assign coolant_warn_out    = st.warn;
  assign limit_lamp_out      = st.lamp;
  assign job_running_out     = (st.job == lmio_pkg::JOB_RUN);
  // helper counters watched only by assertions
  logic [25:0] low_run, since_acc;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      low_run   <= '0;
      since_acc <= '1;
    end else if (clock_en) begin
      low_run   <= !pressed ? '0 :
                   (&low_run ? low_run : low_run + 1'b1);
      since_acc <= acc ? '0 :
                   (&since_acc ? since_acc : since_acc + 1'b1);
    end
  end

  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  property p_pedal_hold;
    clock_en && acc |-> low_run >= 26'(PEDAL_CYC - 1);
  endproperty
  a_pedal_hold: assert property (p_pedal_hold)
    else $error("pedal accepted before its hold time");
  property p_pedal_gap;
    clock_en && acc |-> since_acc >= 26'(PEDAL_CYC);
  endproperty
  a_pedal_gap: assert property (p_pedal_gap)
    else $error("pedal accepted too soon after the last one");
  property p_pedal_start;
    clock_en && acc && !prot_any && !cmd_stop
      && st.job == lmio_pkg::JOB_IDLE |=> st.job == lmio_pkg::JOB_RUN;
  endproperty
  a_pedal_start: assert property (p_pedal_start)
    else $error("accepted pedal did not start the job");
  sequence s_guard_hit;
    clock_en && guard_trip;
  endsequence
  property p_guard_stop;
    s_guard_hit |=> st.laser_on == '0
      && st.job != lmio_pkg::JOB_RUN;
  endproperty
  a_guard_stop: assert property (p_guard_stop)
    else $error("guard trip left laser on or work running");
  property p_guard_off;
    !st.cfg[lmio_pkg::CFG_GUARD_EN] |-> !guard_trip;
  endproperty
  a_guard_off: assert property (p_guard_off)
    else $error("disabled guard produced a trip");
  property p_fire_on;
    clock_en && !q[lmio_pkg::IN_FIRE] && !prot_any
      |=> st.laser_on == '1;
  endproperty
  a_fire_on: assert property (p_fire_on)
    else $error("manual fire did not turn lasers on");
  generate
    for (genvar c = 0; c < NL; c++) begin : g_lchk
      property p_cool;
        clock_en && cool_trip[c] |=> !st.laser_on[c] && st.warn[c];
      endproperty
      a_cool: assert property (p_cool)
        else $error("coolant trip did not force laser off");
      property p_rf_en;
        clock_en && !st.cfg[lmio_pkg::CFG_GLASS + c]
          |=> laser_enable_out[c];
      endproperty
      a_rf_en: assert property (p_rf_en)
        else $error("rf channel drove its enable low");
    end
    for (genvar a = 0; a < NA; a++) begin : g_achk
      property p_step_idle;
        clock_en && !st.cfg[lmio_pkg::CFG_STEP_RISE + a]
          && !axis_step_req[a] && !st.homing[a]
          |=> axis_step_pulse_out[a];
      endproperty
      a_step_idle: assert property (p_step_idle)
        else $error("falling-edge step idle level not high");
      property p_home_end;
        clock_en && st.homing[a] && at_lim[2*a] |=> !st.homing[a];
      endproperty
      a_home_end: assert property (p_home_end)
        else $error("homing continued past the minus limit");
    end
  endgenerate
endmodule

// ==== test/lmio_far_model.sv ====
// far side: pedal, guard door, fire button, limit and coolant contacts
// assumes open contacts read high through pull-ups on the board
`timescale 1ns/1ps
module lmio_far_model (
  input  wire logic       press,
  input  wire logic       door_open,
  input  wire logic       fire_on,
  input  wire logic [7:0] hit,
  input  wire logic [1:0] cool_fault,
  output logic            pedal_pin,
  output logic            guard_pin,
  output logic            fire_pin,
  output logic [7:0]      limit_pin,
  output logic [1:0]      cool_pin
);
  // released pedal is open, the pull-up gives high
  assign pedal_pin = press ? 1'b0 : 1'b1;
  assign guard_pin = door_open;
  assign fire_pin  = ~fire_on;
  // low-active switches close to ground at the limit
  assign limit_pin = ~hit;
  assign cool_pin  = cool_fault;
endmodule

// ==== test/testbench.sv ====
// testbench: bus tasks, far-side model and checks for the io supervisor
// assumes lmio_top with short pedal and homing counts
`timescale 1ns/1ps
module testbench;
  localparam int PC = 20;
  logic        clock = 0, rst_n = 0, press = 0, door = 0, fire = 0, ce = 1;
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [3:0]  awaddr = 0, araddr = 0, step_req = 0, dir_req = 0;
  logic [31:0] wdata = 0, rdata;
  logic [1:0]  fire_req = 0, pwm_req = 0, cool = 0, bresp, rresp;
  logic [7:0]  hit = 0, lamp, limit_pin;
  logic        awready, wready, bvalid, arready, rvalid, running;
  logic        pedal_pin, guard_pin, fire_pin;
  logic [1:0]  cool_pin, en_out, pwm_out, warn;
  logic [3:0]  step_out, dir_out;
  int          fail_count = 0, checks_done = 0;

  always #2.5 clock = ~clock;

  lmio_far_model u_far (.press(press), .door_open(door), .fire_on(fire),
    .hit(hit), .cool_fault(cool), .pedal_pin(pedal_pin),
    .guard_pin(guard_pin), .fire_pin(fire_pin), .limit_pin(limit_pin),
    .cool_pin(cool_pin));

  lmio_top #(.PEDAL_CYC(PC), .HOME_PER_CYC(10), .HOME_PUL_CYC(3)) u_dut (
    .clock(clock), .rst_n(rst_n), .clock_en(ce),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .pedal_switch_in(pedal_pin), .guard_interlock_in(guard_pin),
    .manual_fire_in(fire_pin), .axis_limit_in(limit_pin),
    .coolant_guard_in(cool_pin), .axis_step_req(step_req),
    .axis_dir_req(dir_req), .laser_fire_req(fire_req),
    .laser_pwm_req(pwm_req), .axis_step_pulse_out(step_out),
    .axis_dir_out(dir_out), .laser_enable_out(en_out),
    .laser_power_pwm_out(pwm_out), .coolant_warn_out(warn),
    .limit_lamp_out(lamp), .job_running_out(running));

  function automatic logic [3:0] pol(input logic [3:0] v, flip);
    return v ^ flip;
  endfunction

  task automatic results;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask

  // hangs end the run; the bus has no other way to report one
  task automatic wr(input logic [3:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    int n;
    awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1; bready <= 1;
    for (n = 0; n < 40; n++) begin
      @(posedge clock);
      if (awready) awvalid <= 0;
      if (wready) wvalid <= 0;
      if (bvalid) break;
    end
    bready <= 0;
    r = bresp;
    if (n == 40) begin
      fail_count++;
      results();
    end
    @(posedge clock);
  endtask

  task automatic rd(input logic [3:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    int n;
    araddr <= a; arvalid <= 1; rready <= 1;
    for (n = 0; n < 40; n++) begin
      @(posedge clock);
      if (arready) arvalid <= 0;
      if (rvalid) break;
    end
    rready <= 0;
    d = rdata;
    r = rresp;
    if (n == 40) begin
      fail_count++;
      results();
    end
    @(posedge clock);
  endtask

  task automatic st(input logic [31:0] mask, exp);
    logic [31:0] d;
    logic [1:0]  r;
    rd(4'h8, d, r);
    chk(d & mask, exp);
  endtask

  task automatic pedal(input int gap);
    press <= 1; cyc(PC + 10);
    press <= 0; cyc(gap);
  endtask

  initial begin
    logic [31:0] d, c;
    logic [1:0]  r;
    int          n;
    void'($urandom(87));
    cyc(12);
    rst_n <= 1;
    @(posedge clock);
    chk({step_out, dir_out, en_out}, 10'h3C3);
    chk({warn, lamp, running}, 0);
    rd(4'h0, d, r); chk(d, 0);
    rd(4'hC, d, r); chk(r, 2'h2);
    wr(4'h8, 1, r); chk(r, 2'h2);
    // a low enable must freeze the step outputs at their idle level
    ce <= 0; step_req <= 4'hF; cyc(4);
    chk(step_out, 4'hF);
    ce <= 1; cyc(2);
    chk(step_out, 4'h0);
    $display("test reset done");
    for (int i = 0; i < 16; i++) begin
      c = $urandom & 32'h0000FF00;
      wr(4'h0, c, r);
      step_req <= 4'($urandom); dir_req <= 4'($urandom);
      cyc(2);
      chk(step_out, pol(step_req, ~c[15:12]));
      chk(dir_out, pol(dir_req, c[11:8]));
    end
    step_req <= 0; dir_req <= 0;
    $display("test axes done");
    for (int i = 0; i < 8; i++) begin
      hit <= 8'($urandom);
      wr(4'h0, i[0] ? 32'h0000_0008 : 32'h0000_0000, r); cyc(8);
      chk(lamp, hit);
      st(32'h3FC0, {18'h0, (i[0] ? ~hit : hit), 6'h0});
    end
    hit <= 0; wr(4'h0, 0, r);
    wr(4'h4, 32'h10, r); cyc(4);
    st(32'h4000, 32'h4000);
    chk(dir_out[0], 0);
    n = 0;
    repeat (12) begin
      @(posedge clock);
      n += (step_out[0] == 1'b0);
    end
    chk(n >= 3 && n <= 6, 1);
    hit <= 8'h01; cyc(12);
    st(32'h4000, 0);
    hit <= 0;
    $display("test limits done");
    pedal(4); chk(running, 1);
    pedal(PC + 10); chk(running, 1);
    pedal(PC); st(3, 2);
    pedal(4); st(3, 1);
    $display("test pedal done");
    fire <= 1; cyc(8);
    for (int i = 0; i < 8; i++) begin
      pwm_req <= 2'($urandom); cyc(2);
      chk(pwm_out, pwm_req);
    end
    pwm_req <= 2'h3; door <= 1; cyc(8);
    chk({running, pwm_out}, 3'h7);
    wr(4'h0, 1, r); cyc(8);
    st(32'h000C0027, 32'h26);
    chk(pwm_out, 0);
    wr(4'h4, 1, r); st(3, 2);
    door <= 0; cyc(8);
    chk(pwm_out, 3);
    wr(4'h4, 1, r); st(3, 1);
    cool <= 2'h1; cyc(8);
    chk(warn, 0);
    wr(4'h2 << 1, 0, r);
    wr(4'h0, 2, r); cyc(8);
    chk({warn, pwm_out}, 4'h6);
    st(3, 2);
    cool <= 0; wr(4'h0, 32'h10, r); cyc(8);
    chk(en_out, 2'h2);
    fire <= 0; cyc(8);
    chk({en_out, pwm_out}, 4'hC);
    wr(4'h4, 2, r); st(3, 0);
    // per-channel fire request is honoured only while running
    fire_req <= 2'h2; cyc(4);
    chk(pwm_out, 0);
    wr(4'h4, 1, r); cyc(4);
    chk({en_out, pwm_out}, 4'hE);
    wr(4'h4, 2, r); fire_req <= 0;
    $display("test laser done");
    results();
  end
endmodule
